// [verilog/stack_wake_addr.sv]
// stack wake-up sequencing, tone relay and device address assignment
`timescale 1ns/1ps
// Function
// - each pin has own address select bit
// - pin index equals address status bit
// - address-selected pin forced to input
// - pin mode needs source one plus enable
// - pin mode samples enabled pins into address
// - unselected pins read as zero
// - enable self-clears, address then refuses writes
// - later pin reuse keeps captured address
// - reference on, shutdown, regulator after delay
// - wake enables cores, active, sends tone
// - wake from sleep resets stack registers
// - wake from sleep reloads, reload setup time
// - resume command keeps register contents
// - resume sends tone, next detects count
// - at most forty resume tones sent
// - base sends one-period tone after release
// - source zero enables frame auto addressing
module stack_wake_addr
(
   input logic ref_clk,
   input logic rst_b,
   input logic [stack_pkg::GPIO_N-1:0] gpio_in,
   input logic [stack_pkg::GPIO_N-1:0] addr_input_select,
   input logic [stack_pkg::GPIO_N-1:0] gpio_func_drive,
   output logic [stack_pkg::GPIO_N-1:0] gpio_oe,
   input logic addr_source_select,
   input logic addr_write_enable_set,
   output logic addr_write_enable,
   input logic [stack_pkg::ADDR_W-1:0] stored_address_nonvolatile,
   output logic [stack_pkg::ADDR_W-1:0] device_address_status,
   input logic frame_valid,
   input logic [stack_pkg::ADDR_W-1:0] frame_address,
   output logic frame_block,
   input logic wake_in_b,
   input logic rx_in,
   input logic wake_tone_rx,
   input logic resume_tone_rx,
   input logic sleep_req,
   input logic shutdown_req,
   output logic always_on_reference,
   output logic regulator_output,
   output logic analog_core_regulator,
   output logic digital_core_regulator,
   output logic active,
   output logic reg_reload,
   output logic wake_tone_tx,
   output logic resume_tone_tx
);
   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      stack_pkg::mode_t fsm;
      logic aor;
      logic por_go;
      logic [stack_pkg::ADDR_W-1:0] addr;
      logic wr_en;
      logic pin_phase;
      logic reload;
      logic wake_low;
      logic [stack_pkg::TMR_W-1:0] rx_cnt;
      stack_pkg::tone_t kind;
      logic [stack_pkg::TONE_W-1:0] tone_left;
      logic tone_on;
      logic gap;
   } top_st_t;

   top_st_t s_ff;
   top_st_t nxt_s;
   logic wake_evt;
   logic resume_evt;
   logic wake_hit;
   logic resume_hit;
   logic listen;

   tmr_if setup_t ();
   tmr_if tone_t ();

   cycle_timer u_setup_tmr
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .t(setup_t.timer)
   );

   cycle_timer u_tone_tmr
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .t(tone_t.timer)
   );

   // ***********************************************
   // tone detectors: wake armed only while asleep or off, resume only while asleep
   // ***********************************************
   assign listen = (s_ff.fsm == stack_pkg::M_SHUTDOWN) ||
                   (s_ff.fsm == stack_pkg::M_SLEEP);

   tone_det u_wake_det
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .arm(listen),
      .tone_in(wake_tone_rx),
      .need(stack_pkg::WAKE_DET_N),
      .hit(wake_hit)
   );

   tone_det u_resume_det
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .arm(s_ff.fsm == stack_pkg::M_SLEEP),
      .tone_in(resume_tone_rx),
      .need(stack_pkg::RESUME_DET_N),
      .hit(resume_hit)
   );

   // ***********************************************
   // outputs
   // ***********************************************
   assign gpio_oe = gpio_func_drive & ~addr_input_select;
   assign frame_block = s_ff.wr_en & ~addr_source_select;
   assign addr_write_enable = s_ff.wr_en;
   assign device_address_status = s_ff.addr;
   assign always_on_reference = s_ff.aor;
   assign regulator_output = (s_ff.fsm != stack_pkg::M_POWER_UP);
   assign analog_core_regulator = (s_ff.fsm == stack_pkg::M_RELOAD) ||
                                  (s_ff.fsm == stack_pkg::M_RESUME) ||
                                  (s_ff.fsm == stack_pkg::M_ACTIVE);
   assign digital_core_regulator = analog_core_regulator;
   assign active = (s_ff.fsm == stack_pkg::M_ACTIVE);
   assign reg_reload = s_ff.reload;
   assign wake_tone_tx = s_ff.tone_on && (s_ff.kind == stack_pkg::TONE_WAKE);
   assign resume_tone_tx = s_ff.tone_on &&
                           (s_ff.kind == stack_pkg::TONE_RESUME);

   // ***********************************************
   // next state
   // ***********************************************
   always_comb
   begin
      nxt_s = s_ff;
      setup_t.load = 1'b0;
      setup_t.cycles = stack_pkg::CYC_POR;
      tone_t.load = 1'b0;
      tone_t.cycles = stack_pkg::CYC_TONE;
      nxt_s.aor = 1'b1;
      nxt_s.reload = 1'b0;
      nxt_s.wake_low = ~wake_in_b;
      // base wakes on release of its pin, stack members on tones
      wake_evt = (s_ff.wake_low & wake_in_b) | wake_hit;
      resume_evt = (s_ff.rx_cnt == stack_pkg::CYC_RX_LOW) | resume_hit;
      if ((s_ff.fsm != stack_pkg::M_SLEEP) || rx_in)
         nxt_s.rx_cnt = '0;
      else if (s_ff.rx_cnt != stack_pkg::CYC_RX_LOW)
         nxt_s.rx_cnt = s_ff.rx_cnt + 13'h0001;

      // tone high phase and gap each last one tone period
      if (tone_t.done)
      begin
         if (s_ff.tone_on)
         begin
            nxt_s.tone_on = 1'b0;
            nxt_s.tone_left = s_ff.tone_left - 6'h01;
            if (s_ff.tone_left > 6'h01)
            begin
               nxt_s.gap = 1'b1;
               tone_t.load = 1'b1;
            end
         end
         else if (s_ff.gap)
         begin
            nxt_s.gap = 1'b0;
            nxt_s.tone_on = 1'b1;
            tone_t.load = 1'b1;
         end
      end

      case (s_ff.fsm)
         stack_pkg::M_POWER_UP:
         begin
            if (s_ff.aor && !s_ff.por_go)
            begin
               nxt_s.por_go = 1'b1;
               setup_t.load = 1'b1;
            end
            else if (setup_t.done)
            begin
               nxt_s.fsm = stack_pkg::M_SHUTDOWN;
               nxt_s.reload = 1'b1;
            end
         end
         stack_pkg::M_SHUTDOWN, stack_pkg::M_SLEEP:
         begin
            if (wake_evt)
            begin
               nxt_s.fsm = stack_pkg::M_RELOAD;
               nxt_s.reload = 1'b1;
               setup_t.load = 1'b1;
               setup_t.cycles = stack_pkg::CYC_RELOAD;
            end
            else if (resume_evt && (s_ff.fsm == stack_pkg::M_SLEEP))
            begin
               nxt_s.fsm = stack_pkg::M_RESUME;
               setup_t.load = 1'b1;
               setup_t.cycles = stack_pkg::CYC_RESUME;
            end
         end
         stack_pkg::M_RELOAD, stack_pkg::M_RESUME:
         begin
            if (setup_t.done)
            begin
               nxt_s.fsm = stack_pkg::M_ACTIVE;
               nxt_s.tone_on = 1'b1;
               nxt_s.gap = 1'b0;
               tone_t.load = 1'b1;
               if (s_ff.fsm == stack_pkg::M_RELOAD)
               begin
                  nxt_s.kind = stack_pkg::TONE_WAKE;
                  nxt_s.tone_left = stack_pkg::WAKE_TONES;
               end
               else
               begin
                  nxt_s.kind = stack_pkg::TONE_RESUME;
                  nxt_s.tone_left = stack_pkg::RESUME_TONES_MAX;
               end
            end
         end
         stack_pkg::M_ACTIVE:
         begin
            if (shutdown_req)
               nxt_s.fsm = stack_pkg::M_SHUTDOWN;
            else if (sleep_req)
               nxt_s.fsm = stack_pkg::M_SLEEP;
         end
         default:
            nxt_s.fsm = stack_pkg::M_POWER_UP;
      endcase

      // address assignment
      nxt_s.pin_phase = s_ff.wr_en & addr_source_select & ~s_ff.pin_phase;
      if (s_ff.pin_phase)
      begin
         nxt_s.addr = gpio_in & addr_input_select;
         nxt_s.wr_en = 1'b0;
      end
      else if (s_ff.wr_en && !addr_source_select && frame_valid)
      begin
         nxt_s.addr = frame_address;
         nxt_s.wr_en = 1'b0;
      end
      if (addr_write_enable_set)
         nxt_s.wr_en = 1'b1;
      if (s_ff.reload)
      begin
         nxt_s.addr = stored_address_nonvolatile;
         nxt_s.wr_en = 1'b0;
         nxt_s.pin_phase = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   // ***********************************************
   // assertions
   // ***********************************************
   sequence pin_entry_s;
      s_ff.wr_en && addr_source_select && !s_ff.pin_phase && !s_ff.reload;
   endsequence

   sequence from_reload_s;
      (s_ff.fsm == stack_pkg::M_RELOAD) ##1 (s_ff.fsm == stack_pkg::M_ACTIVE);
   endsequence

   sequence from_resume_s;
      (s_ff.fsm == stack_pkg::M_RESUME) ##1 (s_ff.fsm == stack_pkg::M_ACTIVE);
   endsequence

   AST_SEL_INPUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (gpio_oe & addr_input_select) == '0)
      else $error("address pin driven as output");

   AST_PIN_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      pin_entry_s ##1 !s_ff.reload |=>
      device_address_status == ($past(gpio_in) & $past(addr_input_select)))
      else $error("pin address not captured on first mode cycle");

   AST_SELF_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_ff.pin_phase && !addr_write_enable_set |=> !addr_write_enable)
      else $error("address write enable not self cleared");

   AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !s_ff.wr_en && !s_ff.pin_phase && !s_ff.reload |=>
      $stable(device_address_status))
      else $error("address changed while not writable");

   AST_AUTO_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_ff.wr_en && !addr_source_select && frame_valid && !s_ff.pin_phase &&
      !s_ff.reload && !addr_write_enable_set |=>
      device_address_status == $past(frame_address) && !addr_write_enable)
      else $error("auto address not taken from frame");

   AST_POR_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(regulator_output) |-> always_on_reference && reg_reload)
      else $error("regulator on before reference or without reload");

   AST_WAKE_TONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      from_reload_s |-> wake_tone_tx && analog_core_regulator)
      else $error("no wake tone on entering active");

   AST_RESUME_TONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      from_resume_s |-> resume_tone_tx && !reg_reload)
      else $error("resume path missing tone or reloaded registers");

   AST_SLEEP_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (s_ff.fsm == stack_pkg::M_SLEEP) ##1 (s_ff.fsm == stack_pkg::M_RELOAD)
      |-> reg_reload)
      else $error("wake from sleep without register reload");

   AST_TONE_MAX: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_ff.tone_left <= stack_pkg::RESUME_TONES_MAX)
      else $error("more than forty tones pending");
endmodule

// [verilog/stack_pkg.sv]
// shared constants and types for stack wake-up and addressing logic
package stack_pkg;

   // ***********************************************
   // widths
   // ***********************************************
   localparam int GPIO_N = 6;
   localparam int ADDR_W = 6;
   localparam int TMR_W = 13;
   localparam int TONE_W = 6;
   localparam int DET_W = 6;

   // ***********************************************
   // timing, in ns, and derived cycle counts
   // ***********************************************
   localparam int CLK_NS = 100;
   localparam int T_POR_WKRDY_NS = 100000;
   localparam int T_TONE_NS = 10000;
   localparam int T_RESUME_SETUP_NS = 200000;
   localparam int T_RELOAD_SETUP_NS = 400000;
   localparam int T_RX_LOW_NS = 100000;

   // least time rounded up to whole cycles, never below one
   function automatic logic [TMR_W-1:0] least_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      if (c < 1)
      begin
         c = 1;
      end
      return c[TMR_W-1:0];
   endfunction

   localparam logic [TMR_W-1:0] CYC_POR = least_cyc(T_POR_WKRDY_NS);
   localparam logic [TMR_W-1:0] CYC_TONE = least_cyc(T_TONE_NS);
   localparam logic [TMR_W-1:0] CYC_RESUME = least_cyc(T_RESUME_SETUP_NS);
   localparam logic [TMR_W-1:0] CYC_RELOAD = least_cyc(T_RELOAD_SETUP_NS);
   localparam logic [TMR_W-1:0] CYC_RX_LOW = least_cyc(T_RX_LOW_NS);

   // ***********************************************
   // tone counts and reset values
   // ***********************************************
   localparam logic [DET_W-1:0] WAKE_DET_N = 6'h04;
   localparam logic [DET_W-1:0] RESUME_DET_N = 6'h03;
   localparam logic [TONE_W-1:0] WAKE_TONES = 6'h01;
   localparam logic [TONE_W-1:0] RESUME_TONES_MAX = 6'h28;
   localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;

   typedef enum logic [2:0] {
      M_POWER_UP,
      M_SHUTDOWN,
      M_RELOAD,
      M_RESUME,
      M_ACTIVE,
      M_SLEEP
   } mode_t;

   typedef enum logic {
      TONE_WAKE,
      TONE_RESUME
   } tone_t;

endpackage

// [verilog/tmr_if.sv]
// carrier between a controller and a one-shot cycle timer
`timescale 1ns/1ps
interface tmr_if;
   logic load;
   logic [stack_pkg::TMR_W-1:0] cycles;
   logic done;
   logic busy;
   modport ctl (output load, output cycles, input done, input busy);
   modport timer (input load, input cycles, output done, output busy);
endinterface

// [verilog/cycle_timer.sv]
// one-shot down counter, done pulses in the last counted cycle
`timescale 1ns/1ps
module cycle_timer
(
   input logic ref_clk,
   input logic rst_b,
   tmr_if.timer t
);
   typedef struct packed {
      logic [stack_pkg::TMR_W-1:0] cnt;
      logic busy;
   } tmr_st_t;

   tmr_st_t s_ff;
   tmr_st_t nxt_s;

   assign t.busy = s_ff.busy;
   assign t.done = s_ff.busy && (s_ff.cnt == 13'h0001);

   always_comb
   begin
      nxt_s = s_ff;
      if (t.load)
      begin
         nxt_s.cnt = t.cycles;
         nxt_s.busy = 1'b1;
      end
      else if (s_ff.busy)
      begin
         nxt_s.cnt = s_ff.cnt - 13'h0001;
         nxt_s.busy = (s_ff.cnt != 13'h0001);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end
endmodule

// [verilog/tone_det.sv]
// counts received tones while armed, flags when the count is reached
`timescale 1ns/1ps
module tone_det
(
   input logic ref_clk,
   input logic rst_b,
   input logic arm,
   input logic tone_in,
   input logic [stack_pkg::DET_W-1:0] need,
   output logic hit
);
   typedef struct packed {
      logic [stack_pkg::DET_W-1:0] cnt;
   } det_st_t;

   det_st_t s_ff;
   det_st_t nxt_s;

   assign hit = arm && (s_ff.cnt >= need);

   always_comb
   begin
      nxt_s = s_ff;
      if (!arm)
         nxt_s.cnt = '0;
      else if (tone_in && (s_ff.cnt < need))
         nxt_s.cnt = s_ff.cnt + 6'h01;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end
endmodule

// [dv/stack_neighbor.sv]
// neighbour stack device model: tones down into the block, counts tones up
`timescale 1ns/1ps
module stack_neighbor
(
   input logic ref_clk,
   input logic rst_b,
   input logic wake_tone_tx,
   input logic resume_tone_tx,
   output logic wake_tone_rx,
   output logic resume_tone_rx,
   output int wake_cnt,
   output int resume_cnt,
   output int last_len
);
   logic wake_q;
   logic resume_q;
   int len;

   initial
   begin
      wake_tone_rx = 1'b0;
      resume_tone_rx = 1'b0;
   end

   // one-cycle pulse per detected tone, pulses ten cycles apart
   task automatic send(input logic resume, input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         wake_tone_rx <= ~resume;
         resume_tone_rx <= resume;
         @(posedge ref_clk);
         wake_tone_rx <= 1'b0;
         resume_tone_rx <= 1'b0;
         repeat (8) @(posedge ref_clk);
      end
   endtask

   // tones leaving upward: count them, time the latest wake tone
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wake_q <= 1'b0;
         resume_q <= 1'b0;
         wake_cnt <= 0;
         resume_cnt <= 0;
         len <= 0;
         last_len <= 0;
      end
      else
      begin
         wake_q <= wake_tone_tx;
         resume_q <= resume_tone_tx;
         if (wake_tone_tx && !wake_q)
            wake_cnt <= wake_cnt + 1;
         if (resume_tone_tx && !resume_q)
            resume_cnt <= resume_cnt + 1;
         len <= wake_tone_tx ? len + 1 : 0;
         if (wake_tone_tx)
            last_len <= len + 1;
      end
   end
endmodule

// [dv/stack_wake_addr_test.sv]
// self-checking bench for stack wake-up, tone relay and addressing
`timescale 1ns/1ps
module stack_wake_addr_test;
   localparam logic [5:0] NV_ADDR = 6'h15;
   logic ref_clk, rst_b, addr_source_select, addr_write_enable_set;
   logic frame_valid, wake_in_b, rx_in, sleep_req, shutdown_req;
   logic [5:0] gpio_in, addr_input_select, gpio_func_drive, frame_address;
   logic [5:0] gpio_oe, device_address_status, sel, pins, fa;
   logic addr_write_enable, frame_block, wake_tone_rx, resume_tone_rx;
   logic always_on_reference, regulator_output, analog_core_regulator;
   logic digital_core_regulator, active, reg_reload, wake_tone_tx;
   logic resume_tone_tx;
   int error_cnt, num_checks, cyc, reloads, t0, w0, r0;
   int wake_cnt, resume_cnt, last_len;

   stack_wake_addr DUT (.ref_clk, .rst_b, .gpio_in, .addr_input_select,
      .gpio_func_drive, .gpio_oe, .addr_source_select,
      .addr_write_enable_set, .addr_write_enable,
      .stored_address_nonvolatile(NV_ADDR), .device_address_status,
      .frame_valid, .frame_address, .frame_block, .wake_in_b, .rx_in,
      .wake_tone_rx, .resume_tone_rx, .sleep_req, .shutdown_req,
      .always_on_reference, .regulator_output, .analog_core_regulator,
      .digital_core_regulator, .active, .reg_reload, .wake_tone_tx,
      .resume_tone_tx);

   stack_neighbor nbr (.ref_clk, .rst_b, .wake_tone_tx, .resume_tone_tx,
      .wake_tone_rx, .resume_tone_rx, .wake_cnt, .resume_cnt, .last_len);

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (reg_reload === 1'b1)
         reloads <= reloads + 1;
      if (cyc == 60000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ***************************************
   // helpers
   // ***************************************
   task automatic report_and_stop();
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // leave active by sleep or shutdown request; regulator stays on
   task automatic request(input logic shut);
      step(1);
      sleep_req <= ~shut;
      shutdown_req <= shut;
      step(1);
      sleep_req <= 1'b0;
      shutdown_req <= 1'b0;
      step(4);
      #1;
      check("leave_active", {active, regulator_output}, 2'h1);
   endtask

   task automatic wake_up(input logic by_tone);
      int d;
      w0 = wake_cnt;
      r0 = reloads;
      if (by_tone)
      begin
         nbr.send(1'b0, 3);
         step(20);
         #1;
         check("wake_det", active, 0);
         t0 = cyc;
         nbr.send(1'b0, 1);
      end
      else
      begin
         step(1);
         wake_in_b <= 1'b0;
         step(5);
         wake_in_b <= 1'b1;
         t0 = cyc;
         step(3);
      end
      #1;
      check("cores_on", {analog_core_regulator, digital_core_regulator,
            active}, 3'h6);
      @(posedge ref_clk iff active === 1'b1);
      d = cyc - t0;
      check("reload_time", d >= stack_pkg::CYC_RELOAD &&
            d <= stack_pkg::CYC_RELOAD + 8, 1);
      step(2);
      #1;
      check("reloaded", reloads - r0, 1);
      check("nv_addr", device_address_status, NV_ADDR);
      step(stack_pkg::CYC_TONE + 10);
      #1;
      check("wake_tones", wake_cnt - w0, stack_pkg::WAKE_TONES);
      check("tone_len", last_len, stack_pkg::CYC_TONE);
   endtask

   task automatic resume_check();
      r0 = reloads;
      w0 = resume_cnt;
      @(posedge ref_clk iff active === 1'b1);
      step(8100);
      #1;
      check("keep_addr", device_address_status, fa);
      check("no_reload", reloads - r0, 0);
      check("resume_tones", resume_cnt - w0,
            stack_pkg::RESUME_TONES_MAX);
   endtask

   // ***************************************
   // main sequence
   // ***************************************
   initial
   begin
      {rst_b, addr_source_select, addr_write_enable_set, frame_valid} = '0;
      {sleep_req, shutdown_req, gpio_in, addr_input_select} = '0;
      {gpio_func_drive, frame_address} = '0;
      {wake_in_b, rx_in} = 2'h3;
      void'($urandom(32'h6954));
      step(12);
      rst_b <= 1'b1;
      step(2);
      #1;
      check("aon_ref", always_on_reference, 1);
      step(900);
      #1;
      check("ldo_early", regulator_output, 0);
      @(posedge ref_clk iff regulator_output === 1'b1);
      step(3);
      #1;
      check("por_addr", device_address_status, NV_ADDR);
      check("shutdown", active, 0);
      wake_up(1'b0);
      for (int i = 0; i < 10; i++)
      begin
         sel = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
         pins = 6'($urandom);
         step(1);
         gpio_func_drive <= 6'($urandom);
         gpio_in <= pins;
         addr_input_select <= sel;
         addr_source_select <= 1'b1;
         step(1);
         addr_write_enable_set <= 1'b1;
         step(1);
         addr_write_enable_set <= 1'b0;
         #1;
         check("pin_dir", gpio_oe, gpio_func_drive & ~sel);
         check("wr_en", addr_write_enable, 1);
         step(2);
         gpio_in <= ~pins;
         step(1);
         #1;
         check("pin_addr", device_address_status, pins & sel);
         if (i == 0)
            check("lone_zero", device_address_status, 6'h00);
         check("wr_clear", addr_write_enable, 0);
         step(1);
         addr_input_select <= 6'h00;
         addr_source_select <= 1'b0;
         frame_valid <= 1'b1;
         frame_address <= ~pins;
         step(1);
         frame_valid <= 1'b0;
         step(2);
         #1;
         check("addr_kept", device_address_status, pins & sel);
      end
      fa = NV_ADDR ^ 6'h3F;
      step(1);
      addr_write_enable_set <= 1'b1;
      step(1);
      addr_write_enable_set <= 1'b0;
      frame_valid <= 1'b1;
      frame_address <= fa;
      #1;
      check("fr_block", frame_block, 1);
      step(1);
      frame_valid <= 1'b0;
      step(1);
      #1;
      check("auto_addr", device_address_status, fa);
      check("fr_pass", frame_block, 0);
      request(1'b0);
      step(1);
      rx_in <= 1'b0;
      step(500);
      rx_in <= 1'b1;
      step(1500);
      #1;
      check("short_low", active, 0);
      step(1);
      rx_in <= 1'b0;
      step(stack_pkg::CYC_RX_LOW + 4);
      rx_in <= 1'b1;
      resume_check();
      request(1'b0);
      nbr.send(1'b1, 2);
      step(40);
      #1;
      check("resume_det", active, 0);
      nbr.send(1'b1, 1);
      resume_check();
      request(1'b0);
      wake_up(1'b1);
      request(1'b1);
      wake_up(1'b1);
      request(1'b0);
      wake_up(1'b0);
      request(1'b1);
      report_and_stop();
   end
endmodule
